/* hw/sbsr_pkg.sv */
// constants and carrier types for the status summary byte block
// assumes one core clock; lower status groups feed in from same-clock logic
// Notes on behaviour
// RULE1: bits 0 and 1 of the summary byte have no function and read zero.
// RULE2: bit 2 sets on each new error queue entry, queue holds an error.
// RULE3: with mask bit 2 set, every new error entry raises a service request.
// RULE4: bit 3 sets when any enabled questionable group event bit is set.
// RULE5: bit 4 follows a readable message waiting in the output queue.
// RULE6: bit 5 is the summary of enabled standard event register bits.
// RULE7: bit 6 sets when any other byte bit is set with its mask bit.
// RULE8: bit 7 sets when any enabled operation group event bit is set.
// RULE9: controller should unmask bit 2 and poll the error queue per request.
// RULE10: controller may use bit 4 to read response data automatically.
// RULE11: each group summary is OR of event bits ANDed with enable bits.
// RULE12: mask bit 6 ignored; request raised on enabled bit rising 0 to 1.
// RULE13: byte returned current for both status query and serial poll.
package sbsr_pkg;
  localparam int BYTE_WIDTH = 8;
  localparam int GROUP_WIDTH = 16;
  localparam int EVENT_WIDTH = 8;
  // bit positions in the summary byte
  localparam int UNUSED0_BIT = 0;
  localparam int UNUSED1_BIT = 1;
  localparam int ERROR_BIT = 2;
  localparam int QUES_BIT = 3;
  localparam int MSG_BIT = 4;
  localparam int EVENT_BIT = 5;
  localparam int SUMMARY_BIT = 6;
  localparam int OPER_BIT = 7;
  // reset values
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  // bits that may ever be unmasked: all but unused and the summary bit
  localparam logic [7:0] MASK_WRITABLE = 8'hbc;

  // event and enable parts of one 16 bit status group
  typedef struct packed {
    logic [GROUP_WIDTH-1:0] eventBits;
    logic [GROUP_WIDTH-1:0] enableBits;
  } sbsr_group_type;

  // standard event register and its enable
  typedef struct packed {
    logic [EVENT_WIDTH-1:0] eventBits;
    logic [EVENT_WIDTH-1:0] enableBits;
  } sbsr_event_type;
endpackage

/* hw/sbsr_status_byte.sv */
// status summary byte with request mask and service request generation
// assumes all inputs come from logic on core_clk; strobes are one cycle
module sbsr_status_byte (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // error queue: entry pulse and empty level
  input wire logic errorEntry,
  input wire logic errorQueueEmpty,
  // output queue holds a readable message
  input wire logic messageWaiting,
  // lower status groups
  input wire sbsr_pkg::sbsr_group_type quesGroup,
  input wire sbsr_pkg::sbsr_group_type operGroup,
  input wire sbsr_pkg::sbsr_event_type eventGroup,
  // request mask register write and read back
  input wire logic maskWrite,
  input wire logic [7:0] maskData,
  output logic [7:0] maskValue,
  // status byte query and serial poll
  input wire logic statusQuery,
  input wire logic serialPoll,
  output logic [7:0] readData,
  output logic readValid,
  // live byte and service request
  output logic [7:0] statusByte,
  output logic serviceRequest
);
  logic [7:0] mask_q;
  logic errorFlag_q;
  logic msgFlag_q;
  logic entryDly_q;
  logic [7:0] enabledPrev_q;
  logic serviceRequest_q;
  logic [7:0] readData_q;
  logic readValid_q;
  logic quesFlag;
  logic operFlag;
  logic eventFlag;
  logic [7:0] lowerBits;
  logic [7:0] enabledBits;
  logic summaryFlag;

  // group sum bits
  sbsr_summary #(.WIDTH(sbsr_pkg::GROUP_WIDTH)) quesSum (
    .core_clk(core_clk),
    .resetn(resetn),
    .eventBits(quesGroup.eventBits),
    .enableBits(quesGroup.enableBits),
    .sumFlag(quesFlag)
  );

  sbsr_summary #(.WIDTH(sbsr_pkg::GROUP_WIDTH)) operSum (
    .core_clk(core_clk),
    .resetn(resetn),
    .eventBits(operGroup.eventBits),
    .enableBits(operGroup.enableBits),
    .sumFlag(operFlag)
  );

  sbsr_summary #(.WIDTH(sbsr_pkg::EVENT_WIDTH)) eventSum (
    .core_clk(core_clk),
    .resetn(resetn),
    .eventBits(eventGroup.eventBits),
    .enableBits(eventGroup.enableBits),
    .sumFlag(eventFlag)
  );

  // request mask; bit 6 and unused bits never stored
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      mask_q <= sbsr_pkg::MASK_RESET;
    else if (maskWrite)
      mask_q <= maskData & sbsr_pkg::MASK_WRITABLE; // RULE12
  end

  // error flag: an entry wins over an empty queue in the same cycle
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      errorFlag_q <= 1'b0;
    else if (errorEntry)
      errorFlag_q <= 1'b1; // RULE2
    else if (errorQueueEmpty)
      errorFlag_q <= 1'b0;
  end

  // message flag follows the queue level
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      msgFlag_q <= 1'b0;
    else
      msgFlag_q <= messageWaiting; // RULE5
  end

  // byte without its summary bit; unused bits tied low
  always_comb
  begin
    lowerBits = sbsr_pkg::BYTE_RESET; // RULE1
    lowerBits[sbsr_pkg::ERROR_BIT] = errorFlag_q; // RULE2
    lowerBits[sbsr_pkg::QUES_BIT] = quesFlag; // RULE4
    lowerBits[sbsr_pkg::MSG_BIT] = msgFlag_q; // RULE5
    lowerBits[sbsr_pkg::EVENT_BIT] = eventFlag; // RULE6
    lowerBits[sbsr_pkg::OPER_BIT] = operFlag; // RULE8
  end

  assign enabledBits = lowerBits & mask_q;
  assign summaryFlag = |enabledBits; // RULE7

  always_comb
  begin
    statusByte = lowerBits;
    statusByte[sbsr_pkg::SUMMARY_BIT] = summaryFlag;
  end

  // edge history; entry delayed to line up with the error flag
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      enabledPrev_q <= 8'h00;
      entryDly_q <= 1'b0;
    end
    else
    begin
      enabledPrev_q <= enabledBits;
      entryDly_q <= errorEntry;
    end
  end

  // request on any enabled 0 to 1 change, and on every error entry while mask bit 2 is set so that
  // later entries still interrupt while bit 2 is already set
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      serviceRequest_q <= 1'b0;
    else
      serviceRequest_q <= (|(enabledBits & ~enabledPrev_q)) // RULE12
        | (entryDly_q & mask_q[sbsr_pkg::ERROR_BIT]); // RULE3
  end

  // query and poll both capture the live byte; reading clears nothing
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      readData_q <= sbsr_pkg::BYTE_RESET;
      readValid_q <= 1'b0;
    end
    else
    begin
      readValid_q <= statusQuery | serialPoll; // RULE13
      if (statusQuery | serialPoll)
        readData_q <= statusByte; // RULE13
    end
  end

  assign readData = readData_q;
  assign readValid = readValid_q;
  assign maskValue = mask_q;
  assign serviceRequest = serviceRequest_q;

  // checks
  sequence entryMasked;
    errorEntry && mask_q[sbsr_pkg::ERROR_BIT] && !maskWrite;
  endsequence

  sequence requestTwoLater;
    ##2 serviceRequest;
  endsequence

  sequence readTaken;
    statusQuery || serialPoll;
  endsequence

  unused_bits_zero_a: assert property (@(posedge core_clk) disable iff (!resetn) // RULE1
    statusByte[1:0] == 2'b00 && readData[1:0] == 2'b00)
    else $error("unused status bits not zero");

  error_flag_set_a: assert property (@(posedge core_clk) disable iff (!resetn) // RULE2
    errorEntry |=> statusByte[sbsr_pkg::ERROR_BIT])
    else $error("error entry did not set bit 2");

  entry_request_a: assert property (@(posedge core_clk) disable iff (!resetn) // RULE3
    entryMasked |-> requestTwoLater)
    else $error("masked error entry gave no service request");

  ques_summary_a: assert property (@(posedge core_clk) disable iff (!resetn) // RULE4
    |(quesGroup.eventBits & quesGroup.enableBits) |=> statusByte[sbsr_pkg::QUES_BIT])
    else $error("questionable summary not set");

  message_flag_a: assert property (@(posedge core_clk) disable iff (!resetn) // RULE5
    statusByte[sbsr_pkg::MSG_BIT] == $past(messageWaiting))
    else $error("message flag does not follow queue");

  event_summary_a: assert property (@(posedge core_clk) disable iff (!resetn) // RULE6
    |(eventGroup.eventBits & eventGroup.enableBits) |=> statusByte[sbsr_pkg::EVENT_BIT])
    else $error("event group summary not set");

  summary_bit_a: assert property (@(posedge core_clk) disable iff (!resetn) // RULE7
    statusByte[sbsr_pkg::SUMMARY_BIT] == |(statusByte & maskValue & 8'hbf))
    else $error("request summary flag wrong");

  oper_summary_a: assert property (@(posedge core_clk) disable iff (!resetn) // RULE8
    |(operGroup.eventBits & operGroup.enableBits) |=> statusByte[sbsr_pkg::OPER_BIT])
    else $error("operation summary not set");

  rise_request_a: assert property (@(posedge core_clk) disable iff (!resetn) // RULE12
    $rose(statusByte[sbsr_pkg::SUMMARY_BIT]) |=> serviceRequest)
    else $error("enabled rise gave no service request");

  mask_six_ignored_a: assert property (@(posedge core_clk) disable iff (!resetn) // RULE12
    maskWrite |=> maskValue[sbsr_pkg::SUMMARY_BIT] == 1'b0)
    else $error("mask bit 6 was stored");

  read_current_a: assert property (@(posedge core_clk) disable iff (!resetn) // RULE13
    readTaken |=> readValid && readData == $past(statusByte))
    else $error("read did not return current byte");
endmodule

/* hw/sbsr_summary.sv */
// registered sum bit of one status group
// assumes event and enable vectors come from logic on core_clk
module sbsr_summary #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // group parts
  input wire logic [WIDTH-1:0] eventBits,
  input wire logic [WIDTH-1:0] enableBits,
  // sum bit, one cycle behind its inputs
  output logic sumFlag
);
  logic sum_q;

  // and each event with its enable, or the products
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      sum_q <= 1'b0;
    else
      sum_q <= |(eventBits & enableBits); // RULE11
  end

  assign sumFlag = sum_q;

  sum_follows_a: assert property (@(posedge core_clk) disable iff (!resetn) // RULE11
    sumFlag == |($past(eventBits) & $past(enableBits)))
    else $error("group sum bit does not match enabled events");
endmodule

/* verification/sbsr_ctrl_model.sv */
// remote controller model: serial polls after each service request
// assumes requests are one-cycle pulses launched from core_clk rising edges
module sbsr_ctrl_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // device side
  input wire logic serviceRequest,
  input wire logic readValid,
  input wire logic [7:0] readData,
  output logic serialPoll,
  // control and tally
  input wire logic pollEnable,
  output int msgSeen
);
  timeunit 1ns;
  timeprecision 1ps;
  initial serialPoll = 1'b0;
  // poll on the falling edge so the poll is stable at the next rising edge
  always @(negedge core_clk or negedge resetn)
    if (!resetn)
      serialPoll <= 1'b0;
    else
      serialPoll <= pollEnable & serviceRequest;
  // message flag in any read answer, query or poll, would start a data fetch
  always @(posedge core_clk or negedge resetn)
    if (!resetn)
      msgSeen <= 0;
    else if (readValid && readData[4])
      msgSeen <= msgSeen + 1;
endmodule

/* verification/sbsr_testbench.sv */
// self-checking bench for the status summary byte block
// assumes the design's package is compiled first
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; \
  $display("Error at %0t: got %h want %h", $time, a, b); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, resetn, errorEntry, errorQueueEmpty, messageWaiting;
  logic maskWrite, statusQuery, serialPoll, readValid, serviceRequest;
  logic [7:0] maskData, maskValue, readData, statusByte;
  sbsr_pkg::sbsr_group_type quesGroup, operGroup;
  sbsr_pkg::sbsr_event_type eventGroup;
  logic [7:0] refByte, refMask, prevMasked, expByte, expRd;
  logic refEntry, refSrq, rdTaken;
  logic [7:0] expQ[$];
  logic [31:0] r, r2;
  int err_total, cmp_count, cycles, seed, msgSeen, msgRef;
  sbsr_status_byte i_sbsr_status_byte (.core_clk(core_clk), .resetn(resetn),
    .errorEntry(errorEntry), .errorQueueEmpty(errorQueueEmpty),
    .messageWaiting(messageWaiting), .quesGroup(quesGroup), .operGroup(operGroup),
    .eventGroup(eventGroup), .maskWrite(maskWrite), .maskData(maskData),
    .maskValue(maskValue), .statusQuery(statusQuery), .serialPoll(serialPoll),
    .readData(readData), .readValid(readValid), .statusByte(statusByte),
    .serviceRequest(serviceRequest));
  sbsr_ctrl_model i_sbsr_ctrl_model (.core_clk(core_clk), .resetn(resetn),
    .serviceRequest(serviceRequest), .readValid(readValid), .readData(readData),
    .serialPoll(serialPoll), .pollEnable(1'b1), .msgSeen(msgSeen));
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // bit 6 is the live or of the byte anded with the mask, never stored
  assign expByte = {refByte[7], |(refByte & refMask), refByte[5:0]};
  // reference byte and mask one cycle behind inputs, request one cycle behind those
  always @(posedge core_clk or negedge resetn)
    if (!resetn)
    begin
      {refByte, refMask, prevMasked, refEntry, refSrq} <= '0;
    end
    else
    begin
      refByte[2] <= errorEntry | (refByte[2] & !errorQueueEmpty);
      refByte[3] <= |(quesGroup.eventBits & quesGroup.enableBits);
      refByte[4] <= messageWaiting;
      refByte[5] <= |(eventGroup.eventBits & eventGroup.enableBits);
      refByte[7] <= |(operGroup.eventBits & operGroup.enableBits);
      if (maskWrite)
        refMask <= maskData & 8'hbc;
      prevMasked <= refByte & refMask;
      refEntry <= errorEntry;
      refSrq <= |(refByte & refMask & ~prevMasked) | (refEntry & refMask[2]);
    end
  // note each read at its taking edge; read strobes only move on falls
  always @(posedge core_clk or negedge resetn)
    if (!resetn)
      rdTaken <= 1'b0;
    else
    begin
      rdTaken <= statusQuery | serialPoll;
      if (statusQuery | serialPoll)
        expQ.push_back(expByte);
    end
  // answers checked on the fall, once the launching edge has settled
  always @(negedge core_clk)
    if (resetn)
    begin
      `CHK(readValid, rdTaken)
      if (readValid === 1'b1)
      begin
        expRd = (expQ.size() > 0) ? expQ.pop_front() : 8'hxx;
        `CHK(readData, expRd)
        if (expRd[4])
          msgRef++;
      end
    end
  // cut a hang short
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles >= 20000)
    begin
      err_total++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("compares %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // phase 0 random masks; phase 1 only error flag unmasked, dense entries
  initial
  begin
    seed = 8;
    {resetn, errorEntry, errorQueueEmpty, messageWaiting, maskWrite} = '0;
    {statusQuery, maskData, quesGroup, operGroup, eventGroup} = '0;
    repeat (10) @(posedge core_clk);
    @(negedge core_clk) resetn = 1'b1;
    for (int ph = 0; ph < 2; ph++)
      for (int i = 0; i < 2000; i++)
      begin
        @(negedge core_clk);
        `CHK(statusByte[1:0], 2'b00)
        `CHK(statusByte[2], refByte[2])
        `CHK(statusByte[3], refByte[3])
        `CHK(statusByte[4], refByte[4])
        `CHK(statusByte[5], refByte[5])
        `CHK(statusByte[6], expByte[6])
        `CHK(statusByte[7], refByte[7])
        `CHK(serviceRequest, refSrq)
        `CHK(maskValue, refMask)
        r = $random(seed);
        r2 = $random(seed);
        errorEntry = r[0] & (r[1] | ph[0]);
        errorQueueEmpty = r[2] & r[3] & !ph[0];
        messageWaiting = r[4];
        quesGroup = {16'h1 << r[7:4], r2[15:0]};
        eventGroup = {8'h1 << r[10:8], r[23:16]};
        operGroup = {16'(r[24]) << r[15:12], r2[31:16]};
        maskWrite = ph[0] ? (i == 0) : &r[27:25];
        maskData = ph[0] ? 8'h04 : r2[7:0];
        statusQuery = r[28] & r[29];
      end
    // let the last requests, polls and answers drain before the tallies
    @(negedge core_clk);
    {errorEntry, maskWrite, statusQuery} = '0;
    repeat (5) @(negedge core_clk);
    `CHK(msgSeen, msgRef)
    `CHK(expQ.size(), 0)
    end_of_test();
  end
endmodule
